/* File: src/cvr_responder.sv */
// Verb decoder for routing lists, processing state, coefficients and gains
// Notes on behaviour
// - Surround sum list: 03h then mixer
// - Centre/sub sum list: 04h then mixer
// - Side surround sum list: 05h then mixer
// - Front panel sum list: 25h then mixer
// - Pin lists: four sums, then 26h
// - Digital output pin list: 06h only
// - Converter sum lists: eleven fixed entries
// - Unsupported get answers all zeros
// - Processing state read answers zero
// - Processing state write ignored, answers zero
// - Command word field layout
// - Coefficient index read and write
// - Coefficient read and write via index
// - Single-input widgets ignore read index
// - Converter input mute and gain
// - Mixer per-input mute and gain
// - Channel sums: input mute, output gain
// - Pins: output mute only, muted default
// - Gain write applies selected amplifiers only
// - Gain write right, index, mute, step
module cvr_responder #(
   parameter logic [3:0] CODEC_ADDR = 4'h0,  // Codec address answered
   parameter int         COEF_AW    = 8      // Coefficient index bits that address the memory
) (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        cmd_valid,   // Command word present
   input  wire logic [31:0] cmd_word,    // Command word
   output      logic        rsp_valid,   // Response present, one cycle
   output      logic [31:0] rsp_data     // Response word
);
   // ---------------------------------------------------------------
   // Types and state
   // ---------------------------------------------------------------
   // Sequencer: idle, or the two busy cycles of a coefficient read
   typedef enum logic [1:0] {
      CVR_IDLE,
      CVR_COEF_WAIT,
      CVR_COEF_SEND
   } cvr_phase_e;

   // All registered state of the decoder
   typedef struct packed {
      cvr_phase_e                            phase;      // Sequencer state
      logic                                  rsp_valid;  // Response strobe
      logic [31:0]                           rsp_data;   // Response word
      logic [15:0]                           coef_idx;   // Coefficient index
      logic [3:0]                            adc_mute;   // Converter mute, {node, left}
      logic [3:0][6:0]                       adc_step;   // Converter step, {node, left}
      logic [cvr_pkg::MIXER_INPUTS*2-1:0]    mix_mute;   // Mixer mute per input/chan
      logic [cvr_pkg::MIXER_INPUTS*2-1:0][6:0] mix_step; // Mixer gain per input/chan
      logic [cvr_pkg::NUM_SUMS*2-1:0]        sum_mute;   // Sum input mute per chan
      logic [cvr_pkg::NUM_SUMS*2-1:0][6:0]   sum_step;   // Sum output gain per chan
      logic [cvr_pkg::NUM_PINS*2-1:0]        pin_mute;   // Pin output mute per chan
   } cvr_state_s;

   // Registered state and its next value
   cvr_state_s st;       // Registered state
   cvr_state_s next_st;  // Next state

   // ---------------------------------------------------------------
   // Command field split
   // ---------------------------------------------------------------
   logic [3:0]  cad;       // Codec address
   logic [7:0]  nid;       // Node number
   logic [3:0]  sverb;     // Short verb
   logic [11:0] lverb;     // Long verb
   logic [15:0] pay16;     // Short verb payload
   logic [7:0]  pay8;      // Long verb payload
   logic        mine;      // Command addressed here
   logic [15:0] coef_rd;   // Coefficient memory output
   logic        coef_we;   // Coefficient write strobe

   // Slice the command word into its fields
   assign cad   = cmd_word[cvr_pkg::CAD_MSB:cvr_pkg::CAD_LSB];
   assign nid   = cmd_word[cvr_pkg::NODE_MSB:cvr_pkg::NODE_LSB];
   assign sverb = cmd_word[cvr_pkg::SVERB_MSB:cvr_pkg::SVERB_LSB];
   assign lverb = cmd_word[cvr_pkg::SVERB_MSB:cvr_pkg::LVERB_LSB];
   assign pay16 = cmd_word[15:0];
   assign pay8  = cmd_word[7:0];
   // Taken only when addressed here and not busy with a coefficient read
   assign mine  = cmd_valid && (cad == CODEC_ADDR) && (st.phase == CVR_IDLE);

   // Long verbs have a top nibble of 7 or F; short verbs use the rest
   logic is_long;
   assign is_long = (sverb == 4'h7) || (sverb == 4'hF);

   // Coefficient writes land at the current index
   assign coef_we = mine && !is_long && (sverb == cvr_pkg::VERB_SET_COEF)
                    && (nid == cvr_pkg::NID_VENDOR);

   // ---------------------------------------------------------------
   // Coefficient store
   // ---------------------------------------------------------------
   // Read data lag the index by one clock
   cvr_coef_mem #(
      .ADDR_W (COEF_AW),
      .DATA_W (16)
   ) u_coef (
      .clk     (clk),
      .wr_en   (coef_we),
      .addr    (st.coef_idx[COEF_AW-1:0]),
      .wr_data (pay16),
      .rd_data (coef_rd)
   );

   // ---------------------------------------------------------------
   // Connection list lookup
   // ---------------------------------------------------------------
   // Returns the window of four entries that holds the offset in the payload
   function automatic logic [31:0] conn_list(input logic [7:0] n, input logic [7:0] off);
      logic lo;
      logic mid;
      logic hi;
      // Which window of four entries the offset falls in
      lo  = (off < 8'd4);
      mid = (off >= 8'd4) && (off < 8'd8);
      hi  = (off >= 8'd8) && (off < 8'd12);
      // Anything not listed below answers zero
      conn_list = 32'h0000_0000;
      // Output sums: converter first, mixer second
      if (n == cvr_pkg::NID_SUM_SURR && lo) begin
         conn_list = {16'h0000, cvr_pkg::NID_MIXER, cvr_pkg::ENT_SURR_DAC};
      end else if (n == cvr_pkg::NID_SUM_CLFE && lo) begin
         conn_list = {16'h0000, cvr_pkg::NID_MIXER, cvr_pkg::ENT_CLFE_DAC};
      end else if (n == cvr_pkg::NID_SUM_SIDE && lo) begin
         conn_list = {16'h0000, cvr_pkg::NID_MIXER, cvr_pkg::ENT_SIDE_DAC};
      end else if (n == cvr_pkg::NID_FOUT_SUM && lo) begin
         conn_list = {16'h0000, cvr_pkg::NID_MIXER, cvr_pkg::ENT_FOUT_DAC};
      end else if (n >= cvr_pkg::NID_PIN_FIRST && n <= cvr_pkg::NID_PIN_LAST) begin
         // Pins: the four channel sums, then the front panel sum
         if (lo) begin
            conn_list = cvr_pkg::LIST_PIN_A;
         end else if (mid) begin
            conn_list = cvr_pkg::LIST_PIN_B;
         end
      end else if (n == cvr_pkg::NID_DIG_OUT && lo) begin
         conn_list = {24'h00_0000, cvr_pkg::ENT_DIG_CONV};
      end else if (n == cvr_pkg::NID_ADC_SUM_M || n == cvr_pkg::NID_ADC_SUM_L) begin
         // Converter sums: eleven entries in three windows
         if (lo) begin
            conn_list = cvr_pkg::LIST_ASUM_A;
         end else if (mid) begin
            conn_list = cvr_pkg::LIST_ASUM_B;
         end else if (hi) begin
            conn_list = cvr_pkg::LIST_ASUM_C;
         end
      end
   endfunction : conn_list

   // ---------------------------------------------------------------
   // Gain read decode
   // ---------------------------------------------------------------
   logic        g_out;     // Output side requested
   logic        g_left;    // Left channel requested
   logic [3:0]  g_ridx;    // Read index
   logic [4:0]  mix_rsel;  // Mixer slot on read
   logic [7:0]  gain_rd;   // Gain read byte
   logic [2:0]  pin_i;     // Pin slot
   logic [1:0]  sum_i;     // Sum slot
   logic        adc_i;     // Converter slot

   assign g_out    = pay16[cvr_pkg::GAIN_OUT_BIT];
   assign g_left   = pay16[cvr_pkg::GAIN_LEFT_BIT];
   assign g_ridx   = pay16[cvr_pkg::GAIN_RIDX_MSB:0];
   assign mix_rsel = {g_ridx, g_left};
   // Slot numbers within each node group
   assign pin_i    = nid[2:0] - cvr_pkg::NID_PIN_FIRST[2:0];
   assign sum_i    = nid[1:0];
   assign adc_i    = nid[0];

   // Gain byte of a read; nodes without an amplifier answer zero
   // Single-input widgets never look at the read index
   always_comb begin
      gain_rd = 8'h00;
      if (nid == cvr_pkg::NID_LINE_ADC || nid == cvr_pkg::NID_MIX_ADC) begin
         if (!g_out) begin
            // Converter input amplifier, one source only
            gain_rd = {st.adc_mute[{adc_i, g_left}], st.adc_step[{adc_i, g_left}]};
         end
      end else if (nid == cvr_pkg::NID_MIXER) begin
         if (!g_out && g_ridx < 4'(cvr_pkg::MIXER_INPUTS)) begin
            // Mixer input slot picked by index and channel
            gain_rd = {st.mix_mute[mix_rsel], st.mix_step[mix_rsel]};
         end
      end else if (nid >= cvr_pkg::NID_SUM_FRONT && nid <= cvr_pkg::NID_SUM_SIDE) begin
         if (g_out) begin
            // Output step; the output mute reads zero
            gain_rd = {1'b0, st.sum_step[{sum_i, g_left}]};
         end else begin
            gain_rd = {st.sum_mute[{sum_i, g_left}], 7'h00};
         end
      end else if (nid >= cvr_pkg::NID_PIN_FIRST && nid <= cvr_pkg::NID_PIN_LAST) begin
         if (g_out) begin
            // Output mute only; the step reads zero
            gain_rd = {st.pin_mute[{pin_i, g_left}], 7'h00};
         end
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   logic       w_out;    // Write output amplifier
   logic       w_in;     // Write input amplifier
   logic [1:0] w_ch;     // Channel write enables, bit 1 left
   logic [3:0] w_idx;    // Write input index
   logic       w_mute;   // Mute value
   logic [6:0] w_step;   // Step gain

   assign w_out  = pay16[cvr_pkg::GAIN_OUT_BIT];
   assign w_in   = pay16[cvr_pkg::GAIN_IN_BIT];
   assign w_ch   = {pay16[cvr_pkg::GAIN_LEFT_BIT], pay16[cvr_pkg::GAIN_RIGHT_BIT]};
   assign w_idx  = pay16[cvr_pkg::GAIN_WIDX_MSB:cvr_pkg::GAIN_WIDX_LSB];
   assign w_mute = pay16[cvr_pkg::GAIN_MUTE_BIT];
   assign w_step = pay16[cvr_pkg::GAIN_STEP_MSB:0];

   // Decoder: answers each command taken and updates the stored gains
   always_comb begin
      next_st           = st;
      // The strobe lasts one cycle unless a response is made below
      next_st.rsp_valid = 1'b0;
      unique case (st.phase)
         // Waiting for a command
         CVR_IDLE: begin
            if (mine) begin
               // Default answer: strobe with an all-zero word
               next_st.rsp_valid = 1'b1;
               next_st.rsp_data  = 32'h0000_0000;
               if (is_long) begin
                  // Long verbs: list read, processing state read and write
                  if (lverb == cvr_pkg::VERB_GET_CONN_LIST) begin
                     next_st.rsp_data = conn_list(nid, pay8);
                  end
                  // Processing state read and write keep the zero answer
               end else if (sverb == cvr_pkg::VERB_GET_COEF_IDX) begin
                  // Index read returns the index only on the vendor node
                  if (nid == cvr_pkg::NID_VENDOR) begin
                     next_st.rsp_data = {16'h0000, st.coef_idx};
                  end
               end else if (sverb == cvr_pkg::VERB_SET_COEF_IDX) begin
                  // Index write loads only on the vendor node
                  if (nid == cvr_pkg::NID_VENDOR) begin
                     next_st.coef_idx = pay16;
                  end
               end else if (sverb == cvr_pkg::VERB_GET_COEF) begin
                  if (nid == cvr_pkg::NID_VENDOR) begin
                     // Memory read delays the answer by two more cycles
                     next_st.rsp_valid = 1'b0;
                     next_st.phase     = CVR_COEF_WAIT;
                  end
               end else if (sverb == cvr_pkg::VERB_GET_GAIN) begin
                  // Gain byte from the read decode
                  next_st.rsp_data = {24'h00_0000, gain_rd};
               end else if (sverb == cvr_pkg::VERB_SET_GAIN) begin
                  // Apply only to fields the node implements
                  // Channel enables: bit 0 right, bit 1 left
                  for (int c = 0; c < 2; c++) begin
                     if (w_ch[c]) begin
                        if (nid == cvr_pkg::NID_LINE_ADC || nid == cvr_pkg::NID_MIX_ADC) begin
                           if (w_in) begin
                              // Converter: input amplifier only
                              next_st.adc_mute[{adc_i, 1'(c)}] = w_mute;
                              next_st.adc_step[{adc_i, 1'(c)}] = w_step;
                           end
                        end else if (nid == cvr_pkg::NID_MIXER) begin
                           if (w_in && w_idx < 4'(cvr_pkg::MIXER_INPUTS)) begin
                              // Mixer: the indexed input only
                              next_st.mix_mute[{w_idx, 1'(c)}] = w_mute;
                              next_st.mix_step[{w_idx, 1'(c)}] = w_step;
                           end
                        end else if (nid >= cvr_pkg::NID_SUM_FRONT
                                     && nid <= cvr_pkg::NID_SUM_SIDE) begin
                           if (w_in) begin
                              // Input amplifier: mute only
                              next_st.sum_mute[{sum_i, 1'(c)}] = w_mute;
                           end
                           if (w_out) begin
                              // Output amplifier: step only
                              next_st.sum_step[{sum_i, 1'(c)}] = w_step;
                           end
                        end else if (nid >= cvr_pkg::NID_PIN_FIRST
                                     && nid <= cvr_pkg::NID_PIN_LAST) begin
                           if (w_out) begin
                              // Output amplifier: mute only
                              next_st.pin_mute[{pin_i, 1'(c)}] = w_mute;
                           end
                        end
                     end
                  end
               end
            end
         end
         // Memory output settles
         CVR_COEF_WAIT: begin
            next_st.phase = CVR_COEF_SEND;
         end
         // Send the coefficient
         CVR_COEF_SEND: begin
            next_st.rsp_valid = 1'b1;
            next_st.rsp_data  = {16'h0000, coef_rd};
            next_st.phase     = CVR_IDLE;
         end
         // Unused code: fall back to idle
         default: begin
            next_st.phase = CVR_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State registers
   // ---------------------------------------------------------------
   // Whole decoder state in one register, synchronous reset
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st.phase     <= CVR_IDLE;
         st.rsp_valid <= 1'b0;
         st.rsp_data  <= 32'h0000_0000;
         st.coef_idx  <= cvr_pkg::RST_COEF_IDX;
         st.adc_mute  <= {4{cvr_pkg::RST_OTHER_MUTE}};
         st.adc_step  <= {4{cvr_pkg::RST_STEP}};
         st.mix_mute  <= {(cvr_pkg::MIXER_INPUTS*2){cvr_pkg::RST_MIX_MUTE}};
         st.mix_step  <= {(cvr_pkg::MIXER_INPUTS*2){cvr_pkg::RST_STEP}};
         st.sum_mute  <= {(cvr_pkg::NUM_SUMS*2){cvr_pkg::RST_OTHER_MUTE}};
         st.sum_step  <= {(cvr_pkg::NUM_SUMS*2){cvr_pkg::RST_STEP}};
         st.pin_mute  <= {(cvr_pkg::NUM_PINS*2){cvr_pkg::RST_PIN_MUTE}};
         // The coefficient memory keeps its contents over reset
      end else begin
         // Take the decoder's next state
         st       <= next_st;
      end
   end

   // Response outputs straight from flops
   assign rsp_valid = st.rsp_valid;
   assign rsp_data  = st.rsp_data;
endmodule : cvr_responder

/* File: src/cvr_pkg.sv */
// Package of verb codes, node numbers, field positions and reset values
package cvr_pkg;
   // ---------------------------------------------------------------
   // Command word fields
   // ---------------------------------------------------------------
   localparam int CAD_MSB     = 31;  // Codec address top bit
   localparam int CAD_LSB     = 28;  // Codec address bottom bit
   localparam int NODE_MSB    = 27;  // Node number top bit
   localparam int NODE_LSB    = 20;  // Node number bottom bit
   localparam int SVERB_MSB   = 19;  // Short verb top bit
   localparam int SVERB_LSB   = 16;  // Short verb bottom bit
   localparam int LVERB_LSB   = 8;   // Long verb bottom bit
   // ---------------------------------------------------------------
   // Verb identifiers
   // ---------------------------------------------------------------
   localparam logic [11:0] VERB_GET_CONN_LIST  = 12'hF02;  // Connection list read
   localparam logic [11:0] VERB_GET_PROC_STATE = 12'hF03;  // Processing state read
   localparam logic [11:0] VERB_SET_PROC_STATE = 12'h703;  // Processing state write
   localparam logic [3:0]  VERB_GET_COEF_IDX   = 4'hD;     // Coefficient index read
   localparam logic [3:0]  VERB_SET_COEF_IDX   = 4'h5;     // Coefficient index write
   localparam logic [3:0]  VERB_GET_COEF       = 4'hC;     // Coefficient read
   localparam logic [3:0]  VERB_SET_COEF       = 4'h4;     // Coefficient write
   localparam logic [3:0]  VERB_GET_GAIN       = 4'hB;     // Amplifier gain read
   localparam logic [3:0]  VERB_SET_GAIN       = 4'h3;     // Amplifier gain write
   // ---------------------------------------------------------------
   // Node numbers
   // ---------------------------------------------------------------
   localparam logic [7:0] NID_LINE_ADC  = 8'h08;  // Line converter
   localparam logic [7:0] NID_MIX_ADC   = 8'h09;  // Mix converter
   localparam logic [7:0] NID_MIXER     = 8'h0B;  // Mixer sum node
   localparam logic [7:0] NID_SUM_FRONT = 8'h0C;  // Front sum node
   localparam logic [7:0] NID_SUM_SURR  = 8'h0D;  // Surround sum node
   localparam logic [7:0] NID_SUM_CLFE  = 8'h0E;  // Centre and subwoofer sum node
   localparam logic [7:0] NID_SUM_SIDE  = 8'h0F;  // Side surround sum node
   localparam logic [7:0] NID_PIN_FIRST = 8'h14;  // First analog pin node
   localparam logic [7:0] NID_PIN_LAST  = 8'h1B;  // Last analog pin node
   localparam logic [7:0] NID_DIG_OUT   = 8'h1E;  // Digital output pin node
   localparam logic [7:0] NID_VENDOR    = 8'h20;  // Vendor register node
   localparam logic [7:0] NID_ADC_SUM_M = 8'h22;  // Sum ahead of mix converter
   localparam logic [7:0] NID_ADC_SUM_L = 8'h23;  // Sum ahead of line converter
   localparam logic [7:0] NID_FOUT_SUM  = 8'h26;  // Front panel output sum node
   // ---------------------------------------------------------------
   // Connection list entries
   // ---------------------------------------------------------------
   localparam logic [7:0] ENT_SURR_DAC = 8'h03;  // Surround converter
   localparam logic [7:0] ENT_CLFE_DAC = 8'h04;  // Centre and subwoofer converter
   localparam logic [7:0] ENT_SIDE_DAC = 8'h05;  // Side surround converter
   localparam logic [7:0] ENT_DIG_CONV = 8'h06;  // Digital output converter
   localparam logic [7:0] ENT_FOUT_DAC = 8'h25;  // Front panel converter
   localparam logic [31:0] LIST_PIN_A  = 32'h0F0E_0D0C;  // Pin list, offsets 0-3
   localparam logic [31:0] LIST_PIN_B  = 32'h0000_0026;  // Pin list, offsets 4-7
   localparam logic [31:0] LIST_ASUM_A = 32'h1B1A_1918;  // Converter sum, offsets 0-3
   localparam logic [31:0] LIST_ASUM_B = 32'h1514_1D1C;  // Converter sum, offsets 4-7
   localparam logic [31:0] LIST_ASUM_C = 32'h000B_1716;  // Converter sum, offsets 8-11
   // ---------------------------------------------------------------
   // Gain payload fields
   // ---------------------------------------------------------------
   localparam int GAIN_OUT_BIT   = 15;  // Output amplifier select
   localparam int GAIN_IN_BIT    = 14;  // Input amplifier select (write)
   localparam int GAIN_LEFT_BIT  = 13;  // Left channel select
   localparam int GAIN_RIGHT_BIT = 12;  // Right channel select (write)
   localparam int GAIN_MUTE_BIT  = 7;   // Mute value
   localparam int GAIN_STEP_MSB  = 6;   // Step gain top bit
   localparam int GAIN_WIDX_LSB  = 8;   // Write input index bottom bit
   localparam int GAIN_WIDX_MSB  = 11;  // Write input index top bit
   localparam int GAIN_RIDX_MSB  = 3;   // Read input index top bit
   // ---------------------------------------------------------------
   // Reset values and counts
   // ---------------------------------------------------------------
   localparam int          MIXER_INPUTS   = 10;      // Mixer input count
   localparam int          NUM_PINS       = 8;       // Analog pin count
   localparam int          NUM_SUMS       = 4;       // Channel sum count
   localparam logic [6:0]  RST_STEP       = 7'h00;   // Step gain after reset
   localparam logic        RST_MIX_MUTE   = 1'b1;    // Mixer inputs muted
   localparam logic        RST_PIN_MUTE   = 1'b1;    // Pin outputs muted
   localparam logic        RST_OTHER_MUTE = 1'b0;    // Other mutes clear
   localparam logic [15:0] RST_COEF_IDX   = 16'h0000;  // Coefficient index
   localparam logic [15:0] RST_COEF       = 16'h0000;  // Coefficient contents; unused, the memory is not reset
endpackage : cvr_pkg

/* File: src/cvr_coef_mem.sv */
// Coefficient memory of the vendor register node, registered read data
module cvr_coef_mem #(
   parameter int ADDR_W = 8,   // Index bits kept
   parameter int DATA_W = 16   // Coefficient width
) (
   input  wire logic              clk,
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   output      logic [DATA_W-1:0] rd_data
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] mem [2**ADDR_W];  // Coefficient cells

   // Read the old addressed word into the output flop while any write lands
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[addr] <= wr_data;
      end
      rd_data <= mem[addr];
   end
endmodule : cvr_coef_mem

/* File: dv/cvr_props.sv */
// Checker of responder answers at its ports
module cvr_props #(
   parameter logic [3:0] CODEC_ADDR = 4'h0  // Codec address answered
) (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        cmd_valid,
   input wire logic        rsp_valid,
   input wire logic [31:0] cmd_word,
   input wire logic [31:0] rsp_data
);
   timeunit 1ns / 1ns;
   logic       tk, ls;  // Command addressed here; list read below offset 4
   logic [7:0] nd;      // Addressed node
   assign tk = cmd_valid && cmd_word[31:28] == CODEC_ADDR;
   assign nd = cmd_word[27:20];
   assign ls = tk && cmd_word[19:8] == 12'hF02 && cmd_word[7:0] < 8'h04;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   AST_PGET: assert property (tk && cmd_word[19:8] == 12'hF03 |=> ~|rsp_data) else $error("proc get");
   AST_PSET: assert property (tk && cmd_word[19:8] == 12'h703 |=> rsp_valid) else $error("proc set");
   AST_GSET: assert property (tk && cmd_word[19:16] == 4'h3 |=> ~|rsp_data) else $error("gain set");
   AST_SURR: assert property (ls && nd == 8'h0D |=> rsp_data == 32'h0000_0B03) else $error("surr");
   AST_PINL: assert property (ls && nd inside {[8'h14:8'h1B]} |=> rsp_data == 32'h0F0E_0D0C)
      else $error("pin list");
   AST_DIGL: assert property (ls && nd == 8'h1E |=> rsp_data == 32'h6) else $error("dig list");
   AST_COEF: assert property (tk && cmd_word[27:16] == 12'h20C |=> !rsp_valid[*2] ##1 rsp_valid)
      else $error("coef timing");
   AST_CAUS: assert property (rsp_valid |-> $past(tk) || $past(tk, 3)) else $error("no cause");
endmodule : cvr_props
bind cvr_responder cvr_props #(.CODEC_ADDR(CODEC_ADDR)) u_props (.clk, .sys_rst, .cmd_valid,
   .rsp_valid, .cmd_word, .rsp_data);

/* File: dv/cvr_host.sv */
// Link controller model issuing command words
module cvr_host (
   input  wire logic        clk,
   input  wire logic        rsp_valid,
   input  wire logic [31:0] rsp_data,
   output      logic        cmd_valid = 1'b0,
   output      logic [31:0] cmd_word = 32'h0000_0000
);
   timeunit 1ns / 1ns;
   // Idle word is inverted so a stale command never looks current
   task automatic xfer(input logic [31:0] w, output logic [31:0] r, output logic ok);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_word = w;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd_word = ~w;
      ok = 1'b0;
      repeat (4) if (!ok) begin
         ok = rsp_valid;
         r = rsp_data;
         if (!ok) @(negedge clk);
      end
   endtask : xfer
endmodule : cvr_host

/* File: dv/tb.sv */
// Self-checking bench of the command responder
module tb;
   timeunit 1ns / 1ns;
   logic        clk = 1'b0, sys_rst = 1'b1, cmd_valid, rsp_valid, ok;
   logic [31:0] cmd_word, rsp_data, r, lf = 32'h1ac0_54de;
   logic [79:0] nl = 80'h0D0E_0F26_141B_1E22_2330;  // Nodes for list reads
   logic [15:0] ix, d [2];
   logic [7:0]  n;
   logic [6:0]  s;
   logic [3:0]  m;
   int          fail_count = 0, cmp_count = 0;
   always #25 clk = ~clk;
   cvr_responder dut (.clk, .sys_rst, .cmd_valid, .cmd_word, .rsp_valid, .rsp_data);
   cvr_host u_host (.clk, .rsp_valid, .rsp_data, .cmd_valid, .cmd_word);
   function automatic logic [31:0] rnd();
      lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
      return lf;
   endfunction : rnd
   // Expected connection list word
   function automatic logic [31:0] lst(input logic [7:0] dn, input int o);
      if (dn inside {8'h22, 8'h23}) return o > 11 ? 32'h0 : o > 7 ? 32'h000B_1716 :
         o > 3 ? 32'h1514_1D1C : 32'h1B1A_1918;
      if (dn inside {[8'h14:8'h1B]}) return o > 7 ? 32'h0 : o > 3 ? 32'h26 : 32'h0F0E_0D0C;
      if (o > 3) return 32'h0;
      if (dn inside {[8'h0D:8'h0F]}) return {16'h0B, dn - 8'h0A};
      return dn == 8'h26 ? 32'h0B25 : dn == 8'h1E ? 32'h6 : 32'h0;
   endfunction : lst
   task automatic results();
      $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   // One command and compare; no answer reads as unknown
   task automatic q(input string nm, input logic [11:0] an, input logic [19:0] vp,
      input logic [31:0] e);
      u_host.xfer({an, vp}, r, ok);
      if (!ok) r = 32'hx;
      cmp_count++;
      if (r !== e) begin
         $display("Error %s expected %h seen %h", nm, e, r);
         fail_count++;
      end
   endtask : q
   initial begin : watchdog
      repeat (5000) @(posedge clk);
      fail_count++;
      results();
   end
   initial begin : main
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      n = 8'h14 + 8'(rnd() % 8);
      m = 4'(rnd() % 10);
      s = 7'(rnd() % 32);
      ix = 16'(rnd());
      q("pin mute", {4'h0, n}, 20'hB_A000, 32'h80);
      q("mix mute", 12'h00B, {8'hB2, 8'h0, m}, 32'h80);
      q("mix set", 12'h00B, {8'h36, m, 1'b0, s}, 32'h0);
      q("mix left", 12'h00B, {8'hB2, 8'h0, m}, {25'h0, s});
      q("mix right", 12'h00B, {8'hB0, 8'h0, m}, 32'h80);
      q("adc set", 12'h008, {12'h361, 1'b1, s}, 32'h0);
      q("adc in", 12'h008, 20'hB_2005, {24'h0, 1'b1, s});
      q("sum set", 12'h00C, {12'h390, 1'b1, s}, 32'h0);
      q("sum out", 12'h00C, 20'hB_8000, {25'h0, s});
      q("pin set", {4'h0, n}, {12'h3A0, 1'b0, s}, 32'h0);
      q("pin out", {4'h0, n}, 20'hB_A000, 32'h0);
      q("adc out", 12'h008, 20'hB_A000, 32'h0);
      q("sum mute", 12'h00C, {12'h350, 1'b1, s}, 32'h0);
      q("sum in", 12'h00C, 20'hB_0000, 32'h80);
      q("mix out", 12'h00B, 20'hB_A000, 32'h0);
      q("mix high", 12'h00B, 20'hB_200A, 32'h0);
      q("no amp", 12'h030, 20'hB_A000, 32'h0);
      $display("Gain test done");
      for (int i = 0; i < 130; i++) begin
         n = nl[i % 10 * 8 +: 8];
         q("list", {4'h0, n}, {12'hF02, 8'(i / 10)}, lst(n, i / 10));
      end
      q("proc get", {4'h0, n}, 20'hF_0300, 32'h0);
      q("proc set", 12'h00B, {12'h703, 8'(rnd())}, 32'h0);
      q("foreign", 12'h90D, 20'hF_0200, 32'hx);
      for (int k = 0; k < 4; k++) begin
         if (k < 2) d[k] = 16'(rnd());
         q("index set", 12'h020, {4'h5, ix ^ 16'(k % 2)}, 32'h0);
         q("coef", 12'h020, {k < 2 ? 4'h4 : 4'hC, k < 2 ? d[k % 2] : 16'h0},
            k < 2 ? 32'h0 : {16'h0, d[k % 2]});
      end
      q("index get", 12'h020, 20'hD_0000, {16'h0, ix ^ 16'h1});
      q("idx other", 12'h00B, 20'hD_0000, 32'h0);
      $display("Routing test done");
      results();
   end
endmodule : tb
